// ---- hw/dtc_top.sv ----
// Purpose: Edge timer, period/width capture, transition and rotary counter
// Assumes: Host drives mode, params and a sample strobe per interval
// Notes:   Results stream through a buffer; host pops one per read pulse unless SELECT is SEL_NUM
// Overview of operation
// - Width mode timestamps start, end; reports difference
// - Edge timer ticks once every 1.6 us
// - Polarity 1 measures high, 0 low pulses
// - Period starts falling if select 1, rising 0
// - Period stored only after complete cycle
// - Selector -2 gives starts, -1 gives periods
// - Mode 5 counter, mode 6 rotary
// - Counter mode counts line zero transitions only
// - Transition count saturates at 65535
// - Counting cycle equals sample interval
// - Clockwise rising edge increments position
// - Counterclockwise rising edge decrements position
// - Position is signed 32-bit two's complement
// - Resolution 1 high, 0 quarter steps
// - Rotary stores one position per sample
module dtc_top
  import dtc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [2:0]  MODE,
  input  wire logic        EDGE_SELECT_PARAM,
  input  wire logic        START,
  input  wire logic        SAMPLE,
  input  wire logic        DIGITAL_LINE_ZERO,
  input  wire logic        DIGITAL_LINE_ONE,
  input  wire logic [1:0]  SELECT,
  input  wire logic        READ,
  output      logic        RESULT_VALID,
  output      logic [31:0] RESULT,
  output      logic [31:0] POSITION,
  output      logic        OVERFLOW
);
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [SYNC_LEN-1:0] s0;
    logic [SYNC_LEN-1:0] s1;
    logic [TICK_W-1:0]   div;
    logic [31:0]         timer;
    logic                armed;
    logic [31:0]         t_start;
    logic [31:0]         last_start;
    logic                have_start;
    logic [15:0]         tcount;
    logic [33:0]         pos;
    logic [2:0]          mode_q;
    logic                ovf;
    logic [31:0]         rsp;
    logic                rsp_v;
    logic                keep_start;
  } dtc_state_t;

  dtc_state_t            st_reg, st_next;
  logic                  rise0, fall0, rise1;
  logic [7:0]            gap_reg;
  logic                  gap_seen_reg;
  logic                  tick;
  logic                  push;
  logic [DATA_W-1:0]     push_data;
  logic                  in_ready;
  logic                  out_valid;
  logic                  pop;
  logic [DATA_W-1:0]     out_data;
  logic [$clog2(FIFO_DEPTH):0] level;
  logic                  flush;
  logic                  start_edge, end_edge;

  //////////////////////////////////////////////////////////////////////////
  // Edges: second and third flip-flops compared
  assign rise0   = (st_reg.s0[1] && st_reg.s0[2] == 1'b0) ? 1'b1 : 1'b0;
  assign fall0   = (!st_reg.s0[1] && st_reg.s0[2]);
  assign rise1   = (st_reg.s1[1] && !st_reg.s1[2]);
  assign tick    = (st_reg.div == TICK_W'(TICK_CYC - 1));
  assign flush   = (MODE != st_reg.mode_q);
  assign pop     = READ && out_valid && (SELECT != SEL_NUM);

  // Width: start edge by polarity, end edge opposite
  assign start_edge = EDGE_SELECT_PARAM ? rise0 : fall0;
  assign end_edge   = EDGE_SELECT_PARAM ? fall0 : rise0;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next        = st_reg;
    push           = 1'b0;
    push_data      = '0;
    st_next.s0     = {st_reg.s0[SYNC_LEN-2:0], DIGITAL_LINE_ZERO};
    st_next.s1     = {st_reg.s1[SYNC_LEN-2:0], DIGITAL_LINE_ONE};
    st_next.mode_q = MODE;
    st_next.rsp_v  = 1'b0;
    st_next.div    = tick ? '0 : st_reg.div + TICK_W'(1);
    if (tick) st_next.timer = st_reg.timer + 32'h1;
    if (flush) begin
      st_next.armed      = 1'b0;
      st_next.have_start = 1'b0;
      st_next.tcount     = '0;
      st_next.pos        = '0;
      st_next.ovf        = 1'b0;
    end else if (START) begin
      unique case (MODE)
        MODE_WIDTH: begin
          if (start_edge) begin
            st_next.t_start = st_reg.timer;
            st_next.armed   = 1'b1;
          end else if (end_edge && st_reg.armed) begin
            push          = 1'b1;
            push_data     = {st_reg.t_start,
                             st_reg.timer - st_reg.t_start};
            st_next.armed = 1'b0;
          end
        end
        MODE_PERIOD: begin
          if (EDGE_SELECT_PARAM ? fall0 : rise0) begin
            st_next.t_start    = st_reg.timer;
            st_next.have_start = 1'b1;
            if (st_reg.have_start) begin
              push      = 1'b1;
              push_data = {st_reg.t_start,
                           st_reg.timer - st_reg.t_start};
            end
          end
        end
        MODE_COUNT: begin
          if ((rise0 || fall0) && st_reg.tcount != COUNT_MAX) begin
            st_next.tcount = st_reg.tcount + 16'h1;
          end
          if ((rise0 || fall0) && st_reg.tcount == COUNT_MAX) begin
            st_next.ovf = 1'b1;
          end
          if (SAMPLE) begin
            push           = 1'b1;
            push_data      = {32'h0, 16'h0, st_reg.tcount};
            st_next.tcount = (rise0 || fall0) ? 16'h1 : 16'h0;
          end
        end
        MODE_ROTARY: begin
          if (rise1 && !rise0) st_next.pos = st_reg.pos + 34'h1;
          if (rise0 && !rise1) st_next.pos = st_reg.pos - 34'h1;
          if (SAMPLE) begin
            push      = 1'b1;
            push_data = {32'h0, POSITION};
          end
        end
        default: ;
      endcase
    end
    if (READ) begin
      st_next.rsp_v = 1'b1;
      if (SELECT == SEL_NUM)
        st_next.rsp = 32'(level);
      else if (out_valid)
        st_next.rsp = (SELECT == SEL_START) ? out_data[63:32]
                                            : out_data[31:0];
      else
        st_next.rsp = '0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) st_reg <= '0;
    else st_reg <= st_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // Position: high resolution raw, low resolution quarter
  assign POSITION = EDGE_SELECT_PARAM ? st_reg.pos[31:0]
                  : st_reg.pos[31+LOW_RES_SHIFT:LOW_RES_SHIFT];
  assign RESULT       = st_reg.rsp;
  assign RESULT_VALID = st_reg.rsp_v;
  assign OVERFLOW     = st_reg.ovf;

  dtc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RESET_N   (RESET_N),
    .FLUSH     (flush),
    .IN_VALID  (push),
    .IN_READY  (in_ready),
    .IN_DATA   (push_data),
    .OUT_VALID (out_valid),
    .OUT_READY (pop),
    .OUT_DATA  (out_data),
    .LEVEL     (level)
  );

  //////////////////////////////////////////////////////////////////////////
  // Cycles since the last tick, for the spacing check
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gap_reg      <= 8'h0;
      gap_seen_reg <= 1'b0;
    end else if (tick) begin
      gap_reg      <= 8'h0;
      gap_seen_reg <= 1'b1;
    end else begin
      gap_reg      <= gap_reg + 8'h1;
    end
  end

  chk_tick_period: assert property (@(posedge CLK) disable iff (!RESET_N)
    tick && gap_seen_reg |-> gap_reg == 8'(TICK_CYC - 1)
  ) else $error("tick spacing wrong");
  chk_count_sat: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_reg.tcount == COUNT_MAX && !SAMPLE && !flush |=> st_reg.tcount == COUNT_MAX
  ) else $error("count wrapped");
  chk_cw_inc: assert property (@(posedge CLK) disable iff (!RESET_N)
    START && MODE == MODE_ROTARY && !flush && rise1 && !rise0
    |=> st_reg.pos == $past(st_reg.pos) + 34'h1
  ) else $error("cw did not increment");
  chk_ccw_dec: assert property (@(posedge CLK) disable iff (!RESET_N)
    START && MODE == MODE_ROTARY && !flush && rise0 && !rise1
    |=> st_reg.pos == $past(st_reg.pos) - 34'h1
  ) else $error("ccw did not decrement");
  chk_period_full: assert property (@(posedge CLK) disable iff (!RESET_N)
    push && MODE == MODE_PERIOD |-> st_reg.have_start
  ) else $error("period without full cycle");
  chk_count_push: assert property (@(posedge CLK) disable iff (!RESET_N)
    push && MODE == MODE_COUNT |-> SAMPLE
  ) else $error("count stored off sample");
  chk_count_line: assert property (@(posedge CLK) disable iff (!RESET_N)
    START && MODE == MODE_COUNT && !flush && !SAMPLE && !rise0 && !fall0
    |=> st_reg.tcount == $past(st_reg.tcount)
  ) else $error("counted without line zero edge");
  chk_sel_num: assert property (@(posedge CLK) disable iff (!RESET_N)
    READ && SELECT == SEL_NUM |=> RESULT_VALID && RESULT == 32'($past(level))
  ) else $error("stored count mismatch");
  chk_width_end: assert property (@(posedge CLK) disable iff (!RESET_N)
    push && MODE == MODE_WIDTH |-> push_data[31:0] == st_reg.timer - st_reg.t_start
  ) else $error("width not difference");
  cov_width: cover property (@(posedge CLK) push && MODE == MODE_WIDTH);
  cov_period: cover property (@(posedge CLK) push && MODE == MODE_PERIOD);
  cov_rotary: cover property (@(posedge CLK) push && MODE == MODE_ROTARY);
  cov_sat: cover property (@(posedge CLK) st_reg.ovf);
endmodule

// ---- hw/dtc_pkg.sv ----
// Purpose: Shared constants for the digital edge timer/counter
// Assumes: 20 MHz clock
// Notes:   Mode codes and selectors follow host command values
package dtc_pkg;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam real         TICK_US       = 1.6;
  localparam int unsigned TICK_CYC      = int'(TICK_US * CLK_HZ / 1000000.0);
  localparam int          TICK_W        = 6;
  localparam logic [2:0]  MODE_IDLE     = 3'h0;
  localparam logic [2:0]  MODE_WIDTH    = 3'h3;
  localparam logic [2:0]  MODE_PERIOD   = 3'h4;
  localparam logic [2:0]  MODE_COUNT    = 3'h5;
  localparam logic [2:0]  MODE_ROTARY   = 3'h6;
  localparam logic [1:0]  SEL_NUM       = 2'h0;
  localparam logic [1:0]  SEL_VALUE     = 2'h1;
  localparam logic [1:0]  SEL_START     = 2'h2;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [1:0]  LOW_RES_SHIFT = 2'h2;
  localparam int          SYNC_LEN      = 3;
  localparam int          FIFO_DEPTH    = 32;
  localparam int          DATA_W        = 64;
endpackage

// ---- hw/dtc_fifo.sv ----
// Purpose: Result buffer with valid/ready on both sides
// Assumes: Single clock
// Notes:   Storage is flip-flops indexed by pointers
module dtc_fifo
  import dtc_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  input  wire logic             FLUSH,
  input  wire logic             IN_VALID,
  output      logic             IN_READY,
  input  wire logic [WIDTH-1:0] IN_DATA,
  output      logic             OUT_VALID,
  input  wire logic             OUT_READY,
  output      logic [WIDTH-1:0] OUT_DATA,
  output      logic [$clog2(DEPTH):0] LEVEL
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } dtc_fifo_state_t;
  dtc_fifo_state_t           st_reg, st_next;
  logic [WIDTH-1:0]          mem_reg [DEPTH];
  logic                      push, pop;

  assign IN_READY  = (st_reg.cnt != AW'(0) + (AW+1)'(DEPTH));
  assign OUT_VALID = (st_reg.cnt != '0);
  assign OUT_DATA  = mem_reg[st_reg.rd];
  assign LEVEL     = st_reg.cnt;
  assign push      = IN_VALID && IN_READY;
  assign pop       = OUT_VALID && OUT_READY;

  always_comb begin
    st_next = st_reg;
    if (FLUSH) begin
      st_next = '0;
    end else begin
      if (push) st_next.wr = st_reg.wr + AW'(1);
      if (pop)  st_next.rd = st_reg.rd + AW'(1);
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) st_reg <= '0;
    else st_reg <= st_next;
  end

  always_ff @(posedge CLK) begin
    if (push && !FLUSH) mem_reg[st_reg.wr] <= IN_DATA;
  end

  chk_fifo_bound: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_reg.cnt <= (AW+1)'(DEPTH)) else $error("fifo level over depth");
endmodule

// ---- tb/dtc_sensor.sv ----
// Purpose: Photogate and rotary sensor digital lines
// Assumes: Both lines idle low
// Notes:   Each edge is 8 clocks after the previous edge of the same task call, or after the call itself
module dtc_sensor (
  output logic line_zero,
  output logic line_one
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    line_zero = 1'b0;
    line_one  = 1'b0;
  end
  // Photogate: n transitions on line zero
  task automatic toggle(input int n);
    repeat (n) begin
      #400 line_zero = ~line_zero;
    end
  endtask
  // Encoder: n pulses, cw on line one, ccw on line zero
  task automatic pulse(input bit cw, input int n);
    repeat (n) begin
      #400;
      if (cw) line_one = 1'b1; else line_zero = 1'b1;
      #400;
      if (cw) line_one = 1'b0; else line_zero = 1'b0;
    end
  endtask
endmodule

// ---- tb/dtc_top_tb.sv ----
// Purpose: Self-checking bench for the edge timer/counter
// Assumes: Sensor model drives both digital lines
// Notes:   Reads are scored against a queue of expected results
module dtc_top_tb
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 20000;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic [2:0]  mode   = MODE_IDLE;
  logic        esel   = 1'b0;
  logic        start  = 1'b0;
  logic        sample = 1'b0;
  logic [1:0]  sel    = SEL_NUM;
  logic        rd     = 1'b0;
  logic        l0;
  logic        l1;
  logic        rv;
  logic [31:0] result;
  logic [31:0] position;
  logic        ovf;
  logic [31:0] exp_q[$];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          a;
  int          b;
  int          n[2];
  ////////////////////////////////////////////////////////////////////////////
  dtc_top dut (.CLK(clk), .RESET_N(rst_n), .MODE(mode),
    .EDGE_SELECT_PARAM(esel), .START(start), .SAMPLE(sample),
    .DIGITAL_LINE_ZERO(l0), .DIGITAL_LINE_ONE(l1), .SELECT(sel),
    .READ(rd), .RESULT_VALID(rv), .RESULT(result),
    .POSITION(position), .OVERFLOW(ovf));
  dtc_sensor sen (.line_zero(l0), .line_one(l1));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Read request; the expected answer is queued
  task automatic rd_exp(input logic [1:0] s, input logic [31:0] e);
    @(negedge clk);
    sel = s;
    rd  = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    rd  = 1'b0;
  endtask
  task automatic smp;
    repeat (8) @(negedge clk);
    sample = 1'b1;
    @(negedge clk);
    sample = 1'b0;
  endtask
  // Mode entry through idle so each scenario starts flushed
  task automatic go(input logic [2:0] m, input logic p);
    @(negedge clk);
    mode = MODE_IDLE;
    repeat (4) @(negedge clk);
    mode  = m;
    esel  = p;
    start = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      report_and_stop();
    end
  end
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (exp_q.size() == 0) check("RESULT_VALID", 32'h0, 32'h1);
      else check("RESULT", exp_q.pop_front(), result);
    end
  end
  initial begin
    void'($urandom(32'hCC96));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rd_exp(SEL_NUM, 32'h0);
    for (int p = 0; p < 2; p++) begin
      go(MODE_PERIOD, p[0]);
      sen.toggle(1);
      repeat (8) @(negedge clk);
      rd_exp(SEL_NUM, 32'h0);
      sen.toggle(4);
      repeat (8) @(negedge clk);
      rd_exp(SEL_NUM, (p == 1) ? 32'h1 : 32'h2);
      sen.toggle(1);
    end
    go(MODE_COUNT, 1'b0);
    for (int i = 0; i < 2; i++) begin
      n[i] = 2 * $urandom_range(1, 10);
      fork
        sen.toggle(n[i]);
        sen.pulse(1'b1, 3);
      join
      smp();
    end
    rd_exp(SEL_NUM, 32'h2);
    rd_exp(SEL_VALUE, 32'(n[0]));
    rd_exp(SEL_VALUE, 32'(n[1]));
    rd_exp(SEL_VALUE, 32'h0);
    check("OVERFLOW", 32'h0, 32'(ovf));
    go(MODE_ROTARY, 1'b1);
    a = $urandom_range(1, 12);
    b = $urandom_range(1, 12);
    sen.pulse(1'b1, a);
    repeat (8) @(negedge clk);
    check("POSITION", 32'(a), position);
    sen.pulse(1'b0, b);
    repeat (8) @(negedge clk);
    check("POSITION", 32'(a - b), position);
    smp();
    rd_exp(SEL_NUM, 32'h1);
    rd_exp(SEL_VALUE, 32'(a - b));
    go(MODE_ROTARY, 1'b0);
    a = 4 * $urandom_range(1, 5);
    sen.pulse(1'b1, a);
    repeat (8) @(negedge clk);
    check("POSITION", 32'(a / 4), position);
    repeat (10) @(negedge clk);
    check("PENDING", 32'h0, 32'(exp_q.size()));
    report_and_stop();
  end
endmodule
